// file: flash_access_cfg.svh
// Purpose: constants for the flash sector program access block
// Assumes: 8-bit data, 16-bit addresses, flash at top of address space
// Notes: storage is flip-flops; erased bytes read as all ones
//
// Notes on behaviour
// - Byte programming; whole-array or per-sector erase
// - Tool and board modes reach everything
// - Self-programming mode never writes or erases sector 0
// - Sector erase leaves other sectors intact
// - Sector count follows flash size
// - Sectors 0,1 are 4K; sector 0 at top
// - Protection blocks link reads and all array writes; option byte writes still go through
// - Unprotecting wipes whole array before anything else
// - Protection set only by option byte bit
// - One clock line, one two-way data line
// - Link pins belong to link once attached
`ifndef FLASH_ACCESS_CFG_SVH
`define FLASH_ACCESS_CFG_SVH
`define FSA_FLASH_BYTES 12288
`define FSA_IDX_W 14
`define FSA_SECTOR_BYTES 4096
`define FSA_SECTORS ((`FSA_FLASH_BYTES > 8192) ? 3 : \
   ((`FSA_FLASH_BYTES > 4096) ? 2 : 1))
`define FSA_BASE_ADDR 16'(17'h10000 - 17'(`FSA_FLASH_BYTES))
`define FSA_ERASED 8'hFF
`define FSA_OPT_PROT_BIT 0
`define FSA_OPT_CLK_BIT 1
`define FSA_RSP_OK 8'h01
`define FSA_RSP_REFUSED 8'h00
`define FSA_FRAME_LAST 6'h1F
`define FSA_RSP_LAST 3'h7
`endif

// file: flash_access_pkg.sv
// Purpose: types shared by the flash sector program access block
// Assumes: constants come from flash_access_cfg.svh
// Notes: flash array and option byte live in the system state
`include "flash_access_cfg.svh"
package flash_access_pkg;
   typedef enum logic [7:0] {
      CMD_READ = 8'h01,
      CMD_PROG = 8'h02,
      CMD_ERASE_SECT = 8'h03,
      CMD_ERASE_ALL = 8'h04,
      CMD_OPT_WRITE = 8'h05
   } cmd_t;
   typedef enum logic [1:0] {
      SYS_IDLE = 2'h0,
      SYS_EXEC = 2'h1,
      SYS_WIPE = 2'h3
   } sys_fsm_t;
   typedef enum logic [1:0] {
      LNK_IDLE = 2'h0,
      LNK_SHIFT_IN = 2'h1,
      LNK_WAIT_ACK = 2'h3,
      LNK_SHIFT_OUT = 2'h2
   } link_fsm_t;
endpackage

// file: flash_sector_program_access.sv
// Purpose: flash array with sector rights, read-out protection and a
//          serial programming link on its own clock
// Assumes: link frame is a 0 start bit then 32 bits, MSB first
// Notes: array and option byte keep their contents through reset
`include "flash_access_cfg.svh"
module flash_sector_program_access (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic prog_link_clock,
   input wire logic prog_link_data_in,
   output logic prog_link_data_out,
   output logic prog_link_data_oe,
   input wire logic tool_attach,
   input wire logic socket_mode,
   input wire logic app_req,
   input wire logic [7:0] app_cmd,
   input wire logic [15:0] app_addr,
   input wire logic [7:0] app_wdata,
   output logic app_ready,
   output logic app_ack,
   output logic app_refused,
   output logic [7:0] app_rdata,
   input wire logic app_pin_data_out,
   input wire logic app_pin_data_oe,
   input wire logic app_pin_clk_out,
   input wire logic app_pin_clk_oe,
   output logic gpio_data_out,
   output logic gpio_data_oe,
   output logic gpio_clk_out,
   output logic gpio_clk_oe,
   output logic readout_protect,
   output logic clock_opt_programmed
);
   // ***************************************************
   // State
   // ***************************************************
   typedef struct packed {
      logic [`FSA_FLASH_BYTES-1:0][7:0] mem;
      logic [7:0] opt;
      flash_access_pkg::sys_fsm_t st;
      logic tool_s1;
      logic tool_s2;
      logic sock_s1;
      logic sock_s2;
      logic req_s1;
      logic req_s2;
      logic req_seen;
      logic ack_tgl;
      logic from_link;
      logic [7:0] cmd;
      logic [15:0] addr;
      logic [7:0] wdata;
      logic [7:0] rsp;
      logic app_ready;
      logic app_ack;
      logic app_refused;
      logic [7:0] app_rdata;
      logic gpio_data_out;
      logic gpio_data_oe;
      logic gpio_clk_out;
      logic gpio_clk_oe;
      logic prot;
      logic clk_opt;
   } sys_state_t;

   typedef struct packed {
      flash_access_pkg::link_fsm_t st;
      logic rst_s1;
      logic rst_s2;
      logic din_s1;
      logic din_s2;
      logic ack_s1;
      logic ack_s2;
      logic ack_seen;
      logic req_tgl;
      logic [5:0] cnt;
      logic [31:0] shreg;
      logic [7:0] oreg;
      logic dout;
      logic doe;
   } link_state_t;

   sys_state_t s_r;
   sys_state_t s_nxt;
   link_state_t l_r;
   link_state_t l_nxt;

   // ***************************************************
   // System domain
   // ***************************************************
   always_comb begin
      logic full;
      logic in_rng;
      logic sect0;
      logic prot;
      logic done;
      logic ok;
      logic [7:0] rdat;
      logic [`FSA_IDX_W-1:0] idx;
      logic [1:0] sect;
      logic [15:0] ea;
      s_nxt = s_r;
      full = s_r.tool_s2 | s_r.sock_s2;
      in_rng = s_r.addr >= `FSA_BASE_ADDR;
      idx = `FSA_IDX_W'(s_r.addr - `FSA_BASE_ADDR);
      sect = ~s_r.addr[13:12];
      sect0 = in_rng && (sect == 2'h0);
      prot = ~s_r.opt[`FSA_OPT_PROT_BIT];
      done = 1'b0;
      ok = 1'b0;
      rdat = `FSA_RSP_REFUSED;
      ea = 16'h0000;
      s_nxt.tool_s1 = tool_attach;
      s_nxt.tool_s2 = s_r.tool_s1;
      s_nxt.sock_s1 = socket_mode;
      s_nxt.sock_s2 = s_r.sock_s1;
      s_nxt.req_s1 = l_r.req_tgl;
      s_nxt.req_s2 = s_r.req_s1;
      s_nxt.app_ack = 1'b0;
      unique case (s_r.st)
         flash_access_pkg::SYS_IDLE: begin
            if (app_req && s_r.app_ready) begin
               s_nxt.from_link = 1'b0;
               s_nxt.cmd = app_cmd;
               s_nxt.addr = app_addr;
               s_nxt.wdata = app_wdata;
               s_nxt.st = flash_access_pkg::SYS_EXEC;
            end else if (s_r.req_s2 != s_r.req_seen) begin
               // Link word is held steady until acknowledged
               s_nxt.req_seen = s_r.req_s2;
               s_nxt.from_link = 1'b1;
               s_nxt.cmd = l_r.shreg[31:24];
               s_nxt.addr = l_r.shreg[23:8];
               s_nxt.wdata = l_r.shreg[7:0];
               s_nxt.st = flash_access_pkg::SYS_EXEC;
            end
         end
         flash_access_pkg::SYS_EXEC: begin
            done = 1'b1;
            if (s_r.from_link && !full) begin
               ok = 1'b0;
            end else begin
               unique case (s_r.cmd)
                  flash_access_pkg::CMD_READ: begin
                     ok = in_rng && !(s_r.from_link && prot);
                     if (ok) begin
                        rdat = s_r.mem[idx];
                     end
                  end
                  flash_access_pkg::CMD_PROG: begin
                     ok = in_rng && !prot &&
                        (s_r.from_link || !sect0);
                     if (ok) begin
                        // Programming only clears bits
                        s_nxt.mem[idx] = s_r.mem[idx] & s_r.wdata;
                     end
                  end
                  flash_access_pkg::CMD_ERASE_SECT: begin
                     ok = in_rng && !prot &&
                        (s_r.from_link || !sect0);
                     if (ok) begin
                        for (int i = 0; i < `FSA_FLASH_BYTES; i++) begin
                           ea = 16'(`FSA_BASE_ADDR + 16'(i));
                           if (~ea[13:12] == sect) begin
                              s_nxt.mem[i] = `FSA_ERASED;
                           end
                        end
                     end
                  end
                  flash_access_pkg::CMD_ERASE_ALL: begin
                     ok = s_r.from_link && !prot;
                     if (ok) begin
                        for (int i = 0; i < `FSA_FLASH_BYTES; i++) begin
                           s_nxt.mem[i] = `FSA_ERASED;
                        end
                     end
                  end
                  flash_access_pkg::CMD_OPT_WRITE: begin
                     ok = s_r.from_link;
                     if (ok && prot &&
                         s_r.wdata[`FSA_OPT_PROT_BIT]) begin
                        done = 1'b0;
                        s_nxt.st = flash_access_pkg::SYS_WIPE;
                     end else if (ok) begin
                        s_nxt.opt = s_r.wdata;
                     end
                  end
                  default: begin
                     ok = 1'b0;
                  end
               endcase
            end
         end
         flash_access_pkg::SYS_WIPE: begin
            // Whole array is cleared in the same cycle that protection drops
            for (int i = 0; i < `FSA_FLASH_BYTES; i++) begin
               s_nxt.mem[i] = `FSA_ERASED;
            end
            s_nxt.opt = s_r.wdata;
            done = 1'b1;
            ok = 1'b1;
         end
         default: begin
            s_nxt.st = flash_access_pkg::SYS_IDLE;
         end
      endcase
      if (done) begin
         s_nxt.st = flash_access_pkg::SYS_IDLE;
         if (s_r.from_link) begin
            if (s_r.cmd == flash_access_pkg::CMD_READ) begin
               s_nxt.rsp = rdat;
            end else begin
               s_nxt.rsp = ok ? `FSA_RSP_OK : `FSA_RSP_REFUSED;
            end
            s_nxt.ack_tgl = ~s_r.ack_tgl;
         end else begin
            s_nxt.app_ack = 1'b1;
            s_nxt.app_refused = ~ok;
            s_nxt.app_rdata = rdat;
         end
      end
      s_nxt.app_ready = s_nxt.st == flash_access_pkg::SYS_IDLE;
      s_nxt.gpio_data_out = app_pin_data_out;
      s_nxt.gpio_data_oe = app_pin_data_oe & ~s_r.tool_s2;
      s_nxt.gpio_clk_out = app_pin_clk_out;
      s_nxt.gpio_clk_oe = app_pin_clk_oe & ~s_r.tool_s2;
      s_nxt.prot = ~s_nxt.opt[`FSA_OPT_PROT_BIT];
      s_nxt.clk_opt = ~s_nxt.opt[`FSA_OPT_CLK_BIT];
      if (rst) begin
         s_nxt.st = flash_access_pkg::SYS_IDLE;
         s_nxt.tool_s1 = 1'b0;
         s_nxt.tool_s2 = 1'b0;
         s_nxt.sock_s1 = 1'b0;
         s_nxt.sock_s2 = 1'b0;
         s_nxt.req_s1 = 1'b0;
         s_nxt.req_s2 = 1'b0;
         s_nxt.req_seen = 1'b0;
         s_nxt.ack_tgl = 1'b0;
         s_nxt.from_link = 1'b0;
         s_nxt.cmd = 8'h00;
         s_nxt.addr = 16'h0000;
         s_nxt.wdata = 8'h00;
         s_nxt.rsp = 8'h00;
         s_nxt.app_ready = 1'b0;
         s_nxt.app_ack = 1'b0;
         s_nxt.app_refused = 1'b0;
         s_nxt.app_rdata = 8'h00;
         s_nxt.gpio_data_out = 1'b0;
         s_nxt.gpio_data_oe = 1'b0;
         s_nxt.gpio_clk_out = 1'b0;
         s_nxt.gpio_clk_oe = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      s_r <= s_nxt;
   end

   // ***************************************************
   // Link domain
   // ***************************************************
   always_comb begin
      l_nxt = l_r;
      l_nxt.rst_s1 = rst;
      l_nxt.rst_s2 = l_r.rst_s1;
      l_nxt.din_s1 = prog_link_data_in;
      l_nxt.din_s2 = l_r.din_s1;
      l_nxt.ack_s1 = s_r.ack_tgl;
      l_nxt.ack_s2 = l_r.ack_s1;
      unique case (l_r.st)
         flash_access_pkg::LNK_IDLE: begin
            l_nxt.doe = 1'b0;
            if (!l_r.din_s2) begin
               l_nxt.cnt = 6'h00;
               l_nxt.st = flash_access_pkg::LNK_SHIFT_IN;
            end
         end
         flash_access_pkg::LNK_SHIFT_IN: begin
            l_nxt.shreg = {l_r.shreg[30:0], l_r.din_s2};
            l_nxt.cnt = 6'(l_r.cnt + 6'h01);
            if (l_r.cnt == `FSA_FRAME_LAST) begin
               l_nxt.req_tgl = ~l_r.req_tgl;
               l_nxt.st = flash_access_pkg::LNK_WAIT_ACK;
            end
         end
         flash_access_pkg::LNK_WAIT_ACK: begin
            if (l_r.ack_s2 != l_r.ack_seen) begin
               l_nxt.ack_seen = l_r.ack_s2;
               l_nxt.dout = s_r.rsp[7];
               l_nxt.oreg = {s_r.rsp[6:0], 1'b0};
               l_nxt.doe = 1'b1;
               l_nxt.cnt = 6'h00;
               l_nxt.st = flash_access_pkg::LNK_SHIFT_OUT;
            end
         end
         flash_access_pkg::LNK_SHIFT_OUT: begin
            if (l_r.cnt[2:0] == `FSA_RSP_LAST) begin
               l_nxt.doe = 1'b0;
               // Own answer bits still sit in the sync flops; hide them
               l_nxt.din_s1 = 1'b1;
               l_nxt.din_s2 = 1'b1;
               l_nxt.st = flash_access_pkg::LNK_IDLE;
            end else begin
               l_nxt.dout = l_r.oreg[7];
               l_nxt.oreg = {l_r.oreg[6:0], 1'b0};
               l_nxt.cnt = 6'(l_r.cnt + 6'h01);
            end
         end
         default: begin
            l_nxt.st = flash_access_pkg::LNK_IDLE;
         end
      endcase
      if (l_r.rst_s2) begin
         l_nxt.st = flash_access_pkg::LNK_IDLE;
         l_nxt.ack_seen = 1'b0;
         l_nxt.req_tgl = 1'b0;
         l_nxt.cnt = 6'h00;
         l_nxt.shreg = 32'h0000_0000;
         l_nxt.oreg = 8'h00;
         l_nxt.dout = 1'b0;
         l_nxt.doe = 1'b0;
      end
   end

   always_ff @(posedge prog_link_clock) begin
      l_r <= l_nxt;
   end

   // ***************************************************
   // Outputs
   // ***************************************************
   assign prog_link_data_out = l_r.dout;
   assign prog_link_data_oe = l_r.doe;
   assign app_ready = s_r.app_ready;
   assign app_ack = s_r.app_ack;
   assign app_refused = s_r.app_refused;
   assign app_rdata = s_r.app_rdata;
   assign gpio_data_out = s_r.gpio_data_out;
   assign gpio_data_oe = s_r.gpio_data_oe;
   assign gpio_clk_out = s_r.gpio_clk_out;
   assign gpio_clk_oe = s_r.gpio_clk_oe;
   assign readout_protect = s_r.prot;
   assign clock_opt_programmed = s_r.clk_opt;
endmodule

// file: flash_access_properties.sv
// Purpose: port checks for the flash sector program access block
// Assumes: app and pin side on clk_sys, link answer on link clock
// Notes: bound to every instance of the block
module flash_access_properties (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic prog_link_clock,
   input wire logic prog_link_data_oe,
   input wire logic tool_attach,
   input wire logic app_req,
   input wire logic [7:0] app_cmd,
   input wire logic [15:0] app_addr,
   input wire logic app_ready,
   input wire logic app_ack,
   input wire logic app_refused,
   input wire logic gpio_data_oe,
   input wire logic gpio_clk_oe,
   input wire logic readout_protect
);
   wire logic tk = app_req && app_ready;
   wire logic wr = app_cmd == 8'h02 || app_cmd == 8'h03;
   wire logic gl = app_cmd == 8'h04 || app_cmd == 8'h05;
   sequence busy_s;
      !app_ready && !app_ack ##1 app_ack && app_ready;
   endsequence
   sequence ans_s(r);
      ##2 app_ack && app_refused == r;
   endsequence
   ack_timing_a:
      assert property (@(posedge clk_sys) disable iff (rst)
      tk |=> busy_s) else $error("app answer timing wrong");
   sector_zero_a:
      assert property (@(posedge clk_sys) disable iff (rst)
      tk && wr && app_addr[15:12] == 4'hF |-> ans_s(1'b1))
      else $error("sector 0 write taken");
   below_base_a:
      assert property (@(posedge clk_sys) disable iff (rst)
      tk && wr && app_addr < 16'hD000 |-> ans_s(1'b1))
      else $error("write below flash taken");
   prot_write_a:
      assert property (@(posedge clk_sys) disable iff (rst)
      tk && wr && readout_protect |-> ans_s(1'b1))
      else $error("write while protected taken");
   global_op_a:
      assert property (@(posedge clk_sys) disable iff (rst)
      tk && gl |-> ans_s(1'b1)) else $error("app global op taken");
   upper_write_a:
      assert property (@(posedge clk_sys) disable iff (rst)
      tk && wr && !readout_protect && app_addr[15:12] inside {4'hD, 4'hE}
      |-> ans_s(1'b0)) else $error("sector 1 or 2 write refused");
   pin_owned_a:
      assert property (@(posedge clk_sys) disable iff (rst)
      tool_attach [*5] |-> !gpio_data_oe && !gpio_clk_oe)
      else $error("link pin driven by app");
   answer_len_a:
      assert property (@(posedge prog_link_clock) disable iff (rst)
      $rose(prog_link_data_oe) |-> prog_link_data_oe [*8] ##1
      !prog_link_data_oe) else $error("answer not 8 link cycles");
endmodule
bind flash_sector_program_access flash_access_properties u_props (
   .clk_sys, .rst, .prog_link_clock, .prog_link_data_oe, .tool_attach,
   .app_req, .app_cmd, .app_addr, .app_ready, .app_ack, .app_refused,
   .gpio_data_oe, .gpio_clk_oe, .readout_protect);

// file: prog_tool_model.sv
// Purpose: programming tool at the far end of the serial link
// Assumes: device samples data on rising link clock
// Notes: link clock runs only inside frames and resets
module prog_tool_model (
   output logic prog_link_clock,
   output logic prog_link_data_in,
   input wire logic prog_link_data_out,
   input wire logic prog_link_data_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic drv_en = 1'b0;
   logic drv_bit = 1'b1;
   initial prog_link_clock = 1'b0;
   // Released line is pulled high
   assign prog_link_data_in = prog_link_data_oe ? prog_link_data_out :
      (drv_en ? drv_bit : 1'b1);
   task automatic tick(input int n);
      repeat (n) begin
         #62.5 prog_link_clock = 1'b1;
         #62.5 prog_link_clock = 1'b0;
      end
   endtask
   // Frame out, answer byte back, then idle high
   task automatic xfer(input logic [31:0] w, output logic [7:0] r);
      logic [32:0] f;
      int n;
      f = {1'b0, w};
      drv_en = 1'b1;
      for (int i = 32; i >= 0; i--) begin
         drv_bit = f[i];
         tick(1);
      end
      drv_en = 1'b0;
      n = 0;
      while (prog_link_data_oe !== 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      for (int i = 7; i >= 0; i--) begin
         r[i] = prog_link_data_in;
         tick(1);
      end
      tick(4);
   endtask
endmodule

// file: tb.sv
// Purpose: self-checking bench for the flash sector program access block
// Assumes: tool model drives the serial link
// Notes: app requests change on falling clk_sys edges
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys, rst, tool_attach, socket_mode, app_req;
   logic [7:0] app_cmd, app_wdata, app_rdata;
   logic [15:0] app_addr;
   logic [3:0] pins;
   wire logic prog_link_clock, prog_link_data_in;
   logic prog_link_data_out, prog_link_data_oe, app_ready, app_ack;
   logic app_refused, gpio_data_out, gpio_data_oe, gpio_clk_out;
   logic gpio_clk_oe, readout_protect, clock_opt_programmed;
   wire logic [3:0] gpio_all = {gpio_clk_oe, gpio_clk_out, gpio_data_oe,
      gpio_data_out};
   int fails = 0;
   int samples_checked = 0;
   flash_sector_program_access u_flash_sector_program_access (
      .clk_sys, .rst, .prog_link_clock, .prog_link_data_in,
      .prog_link_data_out, .prog_link_data_oe, .tool_attach,
      .socket_mode, .app_req, .app_cmd, .app_addr, .app_wdata,
      .app_ready, .app_ack, .app_refused, .app_rdata,
      .app_pin_data_out(pins[0]), .app_pin_data_oe(pins[1]),
      .app_pin_clk_out(pins[2]), .app_pin_clk_oe(pins[3]),
      .gpio_data_out, .gpio_data_oe, .gpio_clk_out, .gpio_clk_oe,
      .readout_protect, .clock_opt_programmed);
   prog_tool_model u_prog_tool_model (.prog_link_clock,
      .prog_link_data_in, .prog_link_data_out, .prog_link_data_oe);
   // Main clock, free-running with an 8 ns period, independent of the link clock
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic ap(input logic [7:0] c, input logic [15:0] a,
         input logic [7:0] d, input logic [7:0] er, input logic ef);
      @(negedge clk_sys);
      cmp(app_ready, 1'b1);
      {app_req, app_cmd, app_addr, app_wdata} = {1'b1, c, a, d};
      @(negedge clk_sys);
      app_req = 1'b0;
      @(negedge clk_sys);
      cmp(app_ack, 1'b1);
      cmp(app_refused, ef);
      if (c == 8'h01) cmp(app_rdata, er);
   endtask
   task automatic lk(input logic [7:0] c, input logic [15:0] a,
         input logic [7:0] d, input logic [7:0] er);
      logic [7:0] r;
      u_prog_tool_model.xfer({c, a, d}, r);
      cmp(r, er);
   endtask
   task automatic t_setup;
      lk(8'h05, 16'h0000, 8'hFF, 8'h01);
      lk(8'h04, 16'h0000, 8'h00, 8'h01);
      cmp(readout_protect, 1'b0);
      cmp(clock_opt_programmed, 1'b0);
      ap(8'h01, 16'hD7FF, 8'h00, 8'hFF, 1'b0);
      $display("test setup done");
   endtask
   task automatic t_sectors;
      lk(8'h02, 16'hF000, 8'hA5, 8'h01);
      lk(8'h02, 16'hE000, 8'h3C, 8'h01);
      lk(8'h02, 16'hD000, 8'h5A, 8'h01);
      lk(8'h01, 16'hE000, 8'h00, 8'h3C);
      ap(8'h02, 16'hFFFE, 8'h00, 8'h00, 1'b1);
      ap(8'h03, 16'hF000, 8'h00, 8'h00, 1'b1);
      ap(8'h02, 16'hCFFF, 8'h00, 8'h00, 1'b1);
      ap(8'h04, 16'hD000, 8'h00, 8'h00, 1'b1);
      ap(8'h05, 16'h0000, 8'h00, 8'h00, 1'b1);
      ap(8'h01, 16'hFFFE, 8'h00, 8'hFF, 1'b0);
      ap(8'h01, 16'hF000, 8'h00, 8'hA5, 1'b0);
      ap(8'h03, 16'hE800, 8'h00, 8'h00, 1'b0);
      ap(8'h01, 16'hE000, 8'h00, 8'hFF, 1'b0);
      ap(8'h01, 16'hD000, 8'h00, 8'h5A, 1'b0);
      ap(8'h02, 16'hE010, 8'h0F, 8'h00, 1'b0);
      ap(8'h01, 16'hE010, 8'h00, 8'h0F, 1'b0);
      $display("test sectors done");
   endtask
   task automatic t_protect;
      lk(8'h05, 16'h0000, 8'hFE, 8'h01);
      cmp(readout_protect, 1'b1);
      lk(8'h01, 16'hD000, 8'h00, 8'h00);
      lk(8'h02, 16'hD001, 8'h00, 8'h00);
      lk(8'h04, 16'h0000, 8'h00, 8'h00);
      ap(8'h02, 16'hD000, 8'h00, 8'h00, 1'b1);
      ap(8'h01, 16'hD000, 8'h00, 8'h5A, 1'b0);
      lk(8'h05, 16'h0000, 8'hFD, 8'h01);
      cmp(readout_protect, 1'b0);
      cmp(clock_opt_programmed, 1'b1);
      ap(8'h01, 16'hD000, 8'h00, 8'hFF, 1'b0);
      ap(8'h01, 16'hF000, 8'h00, 8'hFF, 1'b0);
      lk(8'h02, 16'hF000, 8'h12, 8'h01);
      lk(8'h01, 16'hF000, 8'h00, 8'h12);
      $display("test protect done");
   endtask
   task automatic t_pins;
      @(negedge clk_sys);
      tool_attach = 1'b0;
      pins = 4'hF;
      repeat (5) @(negedge clk_sys);
      cmp(gpio_all, 4'hF);
      lk(8'h01, 16'hF000, 8'h00, 8'h00);
      @(negedge clk_sys);
      socket_mode = 1'b1;
      lk(8'h01, 16'hF000, 8'h00, 8'h12);
      @(negedge clk_sys);
      tool_attach = 1'b1;
      repeat (5) @(negedge clk_sys);
      cmp(gpio_all, 4'h5);
      $display("test pins done");
   endtask
   initial begin
      {rst, tool_attach, socket_mode, app_req} = 4'h C;
      {app_cmd, app_addr, app_wdata, pins} = 36'h0;
      repeat (3) @(posedge clk_sys);
      u_prog_tool_model.tick(4);
      @(negedge clk_sys);
      rst = 1'b0; // Kept released through every session
      u_prog_tool_model.tick(4);
      t_setup();
      t_sectors();
      t_protect();
      t_pins();
      give_verdict();
   end
   initial begin
      #400000;
      fails++;
      give_verdict();
   end
endmodule
